//--- loopback_pattern_lane_config_regs.vh
`ifndef LOOPBACK_PATTERN_LANE_CONFIG_REGS_VH
`define LOOPBACK_PATTERN_LANE_CONFIG_REGS_VH

// ==========================================================
// Management addressing
`define DEV_ADDR            5'h1E
`define OFS_LOOP_TP_CTRL    16'h000B
`define OFS_LANE_CFG        16'h000C
`define OFS_MISMATCH_TALLY  16'h000F

// ==========================================================
// Reset values
`define RST_LOOP_TP_CTRL    16'h0D10
`define RST_LANE_CFG        16'h0330

// ==========================================================
// Loopback and test pattern control fields
`define B_FAST_TX_ON        13
`define B_FAST_CHECK_ON     12
`define B_SLOW_CHOICE_TOP   11
`define F_FAST_CHOICE_HI    10
`define F_FAST_CHOICE_LO    8
`define B_SLOW_TX_ON        7
`define B_SLOW_CHECK_ON     6
`define F_SLOW_CHOICE_HI    5
`define F_SLOW_CHOICE_LO    4
`define B_FAR_RETURN        3
`define B_NEAR_RETURN       0

// ==========================================================
// Lane configuration fields
`define F_PICKER_HI         13
`define F_PICKER_LO         12
`define B_LOSS_IGNORE       5
`define B_PLL_IGNORE        4
`define B_REALIGN           2
`define LANE_CFG_RD_MASK    16'hF3F7

// ==========================================================
// Pattern codes
`define PAT_HIGH_FREQ       3'h0
`define PAT_LOW_FREQ        3'h1
`define PAT_MIXED_FREQ      3'h2
`define PAT_CRPAT_LONG      3'h3
`define PAT_CRPAT_SHORT     3'h4
`define PAT_PRBS7           3'h5
`define PAT_PRBS23          3'h6
`define PAT_PRBS31          3'h7

`endif

//--- loopback_pattern_lane_config.v
`timescale 1ns/1ps
`include "loopback_pattern_lane_config_regs.vh"

module loopback_pattern_lane_config (
    input  wire        i_clock,
    input  wire        i_nrst,
    input  wire        i_wr_stb,
    input  wire        i_rd_stb,
    input  wire [4:0]  i_dev_addr,
    input  wire [15:0] i_reg_addr,
    input  wire [15:0] i_wr_data,
    input  wire [1:0]  i_mode,
    input  wire        i_fast_mismatch,
    input  wire        i_slow_mismatch,
    input  wire [3:0]  i_lane_status,
    input  wire [3:0]  i_lane_enable,
    input  wire [3:0]  i_lane_signal_loss,
    input  wire        i_slow_pll_locked,
    input  wire        i_lanes_aligned,
    output reg  [15:0] o_rd_data,
    output reg         o_rd_valid,
    output reg         o_fast_side_pattern_tx_on,
    output reg         o_fast_side_pattern_check_on,
    output reg  [2:0]  o_fast_side_pattern_choice,
    output reg         o_slow_side_pattern_tx_on,
    output reg         o_slow_side_pattern_check_on,
    output reg  [2:0]  o_slow_side_pattern_choice,
    output reg         o_far_return_path_on,
    output reg         o_near_return_path_on,
    output reg         o_lane_realign_force,
    output reg         o_picked_lane_status,
    output reg         o_link_up,
    output reg  [15:0] o_fast_side_mismatch_tally
);

    localparam MODE_KX     = 2'h0;
    localparam MODE_10G    = 2'h1;
    localparam MODE_10G_KR = 2'h2;

    reg  [15:0] ctrl_q;
    reg  [15:0] lane_cfg_q;
    reg  [15:0] tally_q;
    reg  [15:0] tally_d;
    reg  [15:0] rd_d;
    reg  [2:0]  fast_mm_sync_q;
    reg  [15:0] ctrl_d;
    reg  [15:0] lane_cfg_d;
    reg  [15:0] rd_data_d;
    reg         rd_valid_d;
    reg         fast_tx_d;
    reg         fast_check_d;
    reg  [2:0]  fast_choice_d;
    reg         slow_tx_d;
    reg         slow_check_d;
    reg  [2:0]  slow_choice_d;
    reg         far_return_d;
    reg         near_return_d;
    reg         realign_d;
    reg         picked_d;
    reg         link_d;
    reg         fast_ok;
    reg         slow_ok;
    reg         loss_ok;
    reg         pll_ok;
    reg  [3:0]  stat_s0_q;
    reg  [3:0]  stat_s1_q;
    reg  [3:0]  loss_s0_q;
    reg  [3:0]  loss_s1_q;
    reg  [1:0]  pll_s_q;
    reg  [1:0]  algn_s_q;
    reg  [1:0]  mode_s0_q;
    reg  [1:0]  mode_s1_q;

    // ==========================================================
    // Address decode
    function reg_hit;
        input [4:0]  dev;
        input [15:0] addr;
        input [15:0] ofs;
        begin
            reg_hit = (dev == `DEV_ADDR) && (addr == ofs);
        end
    endfunction

    wire        sel_dev = (i_dev_addr == `DEV_ADDR);
    wire        wr_ctrl = i_wr_stb && reg_hit(i_dev_addr, i_reg_addr, `OFS_LOOP_TP_CTRL);
    wire        wr_lane = i_wr_stb && reg_hit(i_dev_addr, i_reg_addr, `OFS_LANE_CFG);
    wire        rd_tally = i_rd_stb && reg_hit(i_dev_addr, i_reg_addr, `OFS_MISMATCH_TALLY);
    wire        tally_full = (tally_q == 16'hFFFF);
    wire [2:0]  fast_code = ctrl_q[`F_FAST_CHOICE_HI:`F_FAST_CHOICE_LO];
    wire [2:0]  slow_code = {ctrl_q[`B_SLOW_CHOICE_TOP], ctrl_q[`F_SLOW_CHOICE_HI:`F_SLOW_CHOICE_LO]};
    wire        fast_mm_pulse = fast_mm_sync_q[1] && !fast_mm_sync_q[2];

    // ==========================================================
    // Pattern legality per mode
    function fast_legal;
        input [2:0] code;
        input [1:0] mode;
        begin
            if (code >= `PAT_PRBS7) begin
                fast_legal = (mode == MODE_KX) || (mode == MODE_10G) || (mode == MODE_10G_KR);
            end else begin
                fast_legal = (mode == MODE_KX) || (mode == MODE_10G);
            end
        end
    endfunction

    function slow_legal;
        input [2:0] code;
        input [1:0] mode;
        begin
            if ((code == `PAT_CRPAT_LONG) || (code == `PAT_CRPAT_SHORT)) begin
                slow_legal = (mode == MODE_KX);
            end else begin
                slow_legal = 1'b1;
            end
        end
    endfunction

    // ==========================================================
    // Fast mismatch synchroniser with edge stage
    always @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            fast_mm_sync_q <= 3'h0;
        end else begin
            fast_mm_sync_q <= {fast_mm_sync_q[1:0], i_fast_mismatch};
        end
    end

    // ==========================================================
    // Lane status and signal loss synchronisers
    always @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            stat_s0_q <= 4'h0;
            stat_s1_q <= 4'h0;
            loss_s0_q <= 4'h0;
            loss_s1_q <= 4'h0;
        end else begin
            stat_s0_q <= i_lane_status;
            stat_s1_q <= stat_s0_q;
            loss_s0_q <= i_lane_signal_loss;
            loss_s1_q <= loss_s0_q;
        end
    end

    // ==========================================================
    // PLL lock, alignment and mode synchronisers
    always @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            pll_s_q   <= 2'h0;
            algn_s_q  <= 2'h0;
            mode_s0_q <= 2'h0;
            mode_s1_q <= 2'h0;
        end else begin
            pll_s_q   <= {pll_s_q[0], i_slow_pll_locked};
            algn_s_q  <= {algn_s_q[0], i_lanes_aligned};
            mode_s0_q <= i_mode;
            mode_s1_q <= mode_s0_q;
        end
    end

    // ==========================================================
    // Register next values
    always @* begin
        ctrl_d     = ctrl_q;
        lane_cfg_d = lane_cfg_q;
        if (wr_ctrl) begin
            ctrl_d = i_wr_data;
        end
        if (wr_lane) begin
            lane_cfg_d = i_wr_data;
        end
    end

    // ==========================================================
    // Registers
    always @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            ctrl_q     <= `RST_LOOP_TP_CTRL;
            lane_cfg_q <= `RST_LANE_CFG;
        end else begin
            ctrl_q     <= ctrl_d;
            lane_cfg_q <= lane_cfg_d;
        end
    end

    // ==========================================================
    // Mismatch tally, clear on read, count wins over clear
    always @* begin
        tally_d = tally_q;
        if (rd_tally) begin
            tally_d = 16'h0000;
        end
        if (fast_mm_pulse && o_fast_side_pattern_check_on && (rd_tally || !tally_full)) begin
            tally_d = tally_d + 16'h0001;
        end
    end

    // ==========================================================
    // Read mux
    always @* begin
        rd_d = 16'h0000;
        if (sel_dev) begin
            case (i_reg_addr)
                `OFS_LOOP_TP_CTRL:   rd_d = ctrl_q;
                `OFS_LANE_CFG:       rd_d = lane_cfg_q & `LANE_CFG_RD_MASK;
                `OFS_MISMATCH_TALLY: rd_d = tally_q;
                default:             rd_d = 16'h0000;
            endcase
        end
    end

    // ==========================================================
    // Pattern legality in the synchronised mode
    always @* begin
        fast_ok = fast_legal(fast_code, mode_s1_q);
        slow_ok = slow_legal(slow_code, mode_s1_q);
    end

    // ==========================================================
    // Link status terms
    always @* begin
        loss_ok = lane_cfg_q[`B_LOSS_IGNORE] || ((loss_s1_q & i_lane_enable) == 4'h0);
        pll_ok  = lane_cfg_q[`B_PLL_IGNORE] || pll_s_q[1];
    end

    // ==========================================================
    // Output next values
    always @* begin
        rd_valid_d    = i_rd_stb;
        rd_data_d     = 16'h0000;
        if (i_rd_stb) begin
            rd_data_d = rd_d;
        end
        fast_tx_d     = ctrl_q[`B_FAST_TX_ON] && fast_ok;
        fast_check_d  = ctrl_q[`B_FAST_CHECK_ON] && fast_ok;
        fast_choice_d = fast_code;
        slow_tx_d     = ctrl_q[`B_SLOW_TX_ON] && slow_ok;
        slow_check_d  = ctrl_q[`B_SLOW_CHECK_ON] && slow_ok;
        slow_choice_d = slow_code;
        far_return_d  = ctrl_q[`B_FAR_RETURN];
        near_return_d = ctrl_q[`B_NEAR_RETURN];
        realign_d     = lane_cfg_q[`B_REALIGN];
        picked_d      = stat_s1_q[lane_cfg_q[`F_PICKER_HI:`F_PICKER_LO]];
        link_d        = algn_s_q[1] && !o_lane_realign_force && loss_ok && pll_ok;
    end

    // ==========================================================
    // Outputs
    always @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            tally_q                      <= 16'h0000;
            o_rd_data                    <= 16'h0000;
            o_rd_valid                   <= 1'b0;
            o_fast_side_pattern_tx_on    <= 1'b0;
            o_fast_side_pattern_check_on <= 1'b0;
            o_fast_side_pattern_choice   <= `PAT_PRBS7;
            o_slow_side_pattern_tx_on    <= 1'b0;
            o_slow_side_pattern_check_on <= 1'b0;
            o_slow_side_pattern_choice   <= `PAT_PRBS7;
            o_far_return_path_on         <= 1'b0;
            o_near_return_path_on        <= 1'b0;
            o_lane_realign_force         <= 1'b0;
            o_picked_lane_status         <= 1'b0;
            o_link_up                    <= 1'b0;
            o_fast_side_mismatch_tally   <= 16'h0000;
        end else begin
            tally_q                      <= tally_d;
            o_fast_side_mismatch_tally   <= tally_d;
            o_rd_valid                   <= rd_valid_d;
            o_rd_data                    <= rd_data_d;
            o_fast_side_pattern_tx_on    <= fast_tx_d;
            o_fast_side_pattern_check_on <= fast_check_d;
            o_fast_side_pattern_choice   <= fast_choice_d;
            o_slow_side_pattern_tx_on    <= slow_tx_d;
            o_slow_side_pattern_check_on <= slow_check_d;
            o_slow_side_pattern_choice   <= slow_choice_d;
            o_far_return_path_on         <= far_return_d;
            o_near_return_path_on        <= near_return_d;
            o_lane_realign_force         <= realign_d;
            o_picked_lane_status         <= picked_d;
            o_link_up                    <= link_d;
        end
    end

endmodule // loopback_pattern_lane_config

//--- loopback_pattern_lane_config_chk.sv
`timescale 1ns/1ps
`include "loopback_pattern_lane_config_regs.vh"
// ==========================================================
// Register and control output checks
module loopback_pattern_lane_config_chk (
    input wire        i_clock,
    input wire        i_nrst,
    input wire        i_wr_stb,
    input wire        i_rd_stb,
    input wire [4:0]  i_dev_addr,
    input wire [15:0] i_reg_addr,
    input wire [15:0] i_wr_data,
    input wire        o_rd_valid,
    input wire        o_fast_side_pattern_tx_on,
    input wire        o_fast_side_pattern_check_on,
    input wire [2:0]  o_fast_side_pattern_choice,
    input wire [2:0]  o_slow_side_pattern_choice,
    input wire        o_far_return_path_on,
    input wire        o_near_return_path_on,
    input wire        o_lane_realign_force,
    input wire        o_link_up
);
    wire wc = i_wr_stb && i_dev_addr == `DEV_ADDR && i_reg_addr == `OFS_LOOP_TP_CTRL;
    wire wl = i_wr_stb && i_dev_addr == `DEV_ADDR && i_reg_addr == `OFS_LANE_CFG;
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_nrst);
    property p_rdv; i_rd_stb |=> o_rd_valid; endproperty
    a_rdv: assert property (p_rdv) else $error("read not answered");
    property p_near; wc |-> ##2 o_near_return_path_on == $past(i_wr_data[0], 2); endproperty
    a_near: assert property (p_near) else $error("near path wrong");
    property p_far; wc |-> ##2 o_far_return_path_on == $past(i_wr_data[3], 2); endproperty
    a_far: assert property (p_far) else $error("far path wrong");
    property p_fch; wc |-> ##2 o_fast_side_pattern_choice == $past(i_wr_data[10:8], 2); endproperty
    a_fch: assert property (p_fch) else $error("fast choice wrong");
    property p_sch;
        wc |-> ##2 o_slow_side_pattern_choice == {$past(i_wr_data[11], 2), $past(i_wr_data[5:4], 2)};
    endproperty
    a_sch: assert property (p_sch) else $error("slow choice wrong");
    property p_txoff; wc && !i_wr_data[13] |-> ##2 !o_fast_side_pattern_tx_on; endproperty
    a_txoff: assert property (p_txoff) else $error("fast tx not off");
    property p_chkoff; wc && !i_wr_data[12] |-> ##2 !o_fast_side_pattern_check_on; endproperty
    a_chkoff: assert property (p_chkoff) else $error("fast check not off");
    property p_realign; wl |-> ##2 o_lane_realign_force == $past(i_wr_data[2], 2); endproperty
    a_realign: assert property (p_realign) else $error("realign wrong");
    property p_link; o_lane_realign_force ##1 o_lane_realign_force |-> !o_link_up; endproperty
    a_link: assert property (p_link) else $error("link up in realign");
endmodule // loopback_pattern_lane_config_chk
bind loopback_pattern_lane_config loopback_pattern_lane_config_chk u_chk (.i_clock(i_clock), .i_nrst(i_nrst),
    .i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb), .i_dev_addr(i_dev_addr), .i_reg_addr(i_reg_addr),
    .i_wr_data(i_wr_data), .o_rd_valid(o_rd_valid), .o_fast_side_pattern_tx_on(o_fast_side_pattern_tx_on),
    .o_fast_side_pattern_check_on(o_fast_side_pattern_check_on),
    .o_fast_side_pattern_choice(o_fast_side_pattern_choice), .o_slow_side_pattern_choice(o_slow_side_pattern_choice),
    .o_far_return_path_on(o_far_return_path_on), .o_near_return_path_on(o_near_return_path_on),
    .o_lane_realign_force(o_lane_realign_force), .o_link_up(o_link_up));

//--- loopback_pattern_lane_config_bench.sv
`timescale 1ns/1ps
`include "loopback_pattern_lane_config_regs.vh"
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin failures++; \
    $display("MISMATCH %s expected %0h seen %0h", n, e, g); end end
// ==========================================================
// Bench top
module loopback_pattern_lane_config_bench;
    reg        i_clock = 0, i_nrst = 0, i_wr_stb = 0, i_rd_stb = 0, i_fast_mismatch = 0;
    reg        i_slow_pll_locked = 0, i_lanes_aligned = 0, e;
    reg [4:0]  i_dev_addr = 0;
    reg [15:0] i_reg_addr = 0, i_wr_data = 0, v;
    reg [1:0]  i_mode = 0;
    reg [3:0]  i_lane_status = 0, i_lane_enable = 0, i_lane_signal_loss = 0;
    wire [15:0] o_rd_data, o_tally;
    wire [2:0]  o_fch, o_sch;
    wire        o_rd_valid, o_ftx, o_fck, o_stx, o_sck, o_far, o_near, o_realign, o_pick, o_link_up;
    integer     failures = 0, samples_checked = 0, seed, m, c;
    loopback_pattern_lane_config u_dut (.i_clock(i_clock), .i_nrst(i_nrst), .i_wr_stb(i_wr_stb),
        .i_rd_stb(i_rd_stb), .i_dev_addr(i_dev_addr), .i_reg_addr(i_reg_addr), .i_wr_data(i_wr_data),
        .i_mode(i_mode), .i_fast_mismatch(i_fast_mismatch), .i_slow_mismatch(1'b0),
        .i_lane_status(i_lane_status), .i_lane_enable(i_lane_enable), .i_lane_signal_loss(i_lane_signal_loss),
        .i_slow_pll_locked(i_slow_pll_locked), .i_lanes_aligned(i_lanes_aligned), .o_rd_data(o_rd_data),
        .o_rd_valid(o_rd_valid), .o_fast_side_pattern_tx_on(o_ftx), .o_fast_side_pattern_check_on(o_fck),
        .o_fast_side_pattern_choice(o_fch), .o_slow_side_pattern_tx_on(o_stx),
        .o_slow_side_pattern_check_on(o_sck), .o_slow_side_pattern_choice(o_sch), .o_far_return_path_on(o_far),
        .o_near_return_path_on(o_near), .o_lane_realign_force(o_realign), .o_picked_lane_status(o_pick),
        .o_link_up(o_link_up), .o_fast_side_mismatch_tally(o_tally));
    function fl(input integer cd, input integer md); fl = (cd > 4 && md < 3) || md < 2; endfunction
    function sl(input integer cd, input integer md); sl = (cd != 3 && cd != 4) || md == 0; endfunction
    task tick(input integer n); begin repeat (n) @(posedge i_clock); #1; end endtask
    task wr(input [4:0] d, input [15:0] a, input [15:0] x); begin
        tick(1); i_wr_stb = 1; i_dev_addr = d; i_reg_addr = a; i_wr_data = x; tick(1); i_wr_stb = 0;
    end endtask
    task rd(input [4:0] d, input [15:0] a, input [15:0] x); begin
        tick(1); i_rd_stb = 1; i_dev_addr = d; i_reg_addr = a; tick(1); i_rd_stb = 0;
        `CHK("rd_valid", 1'b1, o_rd_valid)
        `CHK("rd_data", x, o_rd_data)
    end endtask
    task finish_test; begin
        $display("failures=%0d samples_checked=%0d", failures, samples_checked);
        if (failures == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    end endtask
    initial begin forever #12.5 i_clock = ~i_clock; end
    initial begin #100000; failures++; finish_test; end
    initial begin
        seed = 21929;
        tick(6); i_nrst = 1;
        `CHK("choice_reset", 3'h5, o_fch)
        rd(`DEV_ADDR, `OFS_LOOP_TP_CTRL, 16'h0D10);
        rd(`DEV_ADDR, `OFS_LANE_CFG, 16'h0330);
        rd(`DEV_ADDR, 16'h0010, 16'h0000);
        wr(5'h01, `OFS_LOOP_TP_CTRL, 16'h0000);
        rd(5'h01, `OFS_LOOP_TP_CTRL, 16'h0000);
        rd(`DEV_ADDR, `OFS_LOOP_TP_CTRL, 16'h0D10);
        for (m = 0; m < 4; m++) begin
            i_mode = m; tick(3);
            for (c = 0; c < 8; c++) begin
                v = $random(seed); v[10:8] = c; v[11] = c[2]; v[5:4] = c[1:0];
                wr(`DEV_ADDR, `OFS_LOOP_TP_CTRL, v); rd(`DEV_ADDR, `OFS_LOOP_TP_CTRL, v);
                `CHK("fast_choice", c[2:0], o_fch)
                `CHK("fast_tx", v[13] & fl(c, m), o_ftx)
                `CHK("fast_check", v[12] & fl(c, m), o_fck)
                `CHK("slow_choice", c[2:0], o_sch)
                `CHK("slow_tx", v[7] & sl(c, m), o_stx)
                `CHK("slow_check", v[6] & sl(c, m), o_sck)
                `CHK("far_path", v[3], o_far)
                `CHK("near_path", v[0], o_near)
            end
        end
        i_mode = 0; tick(3); wr(`DEV_ADDR, `OFS_LOOP_TP_CTRL, 16'h1510);
        rd(`DEV_ADDR, `OFS_MISMATCH_TALLY, 16'h0000);
        repeat (3) begin i_fast_mismatch = 1; tick(3); i_fast_mismatch = 0; tick(3); end
        `CHK("tally_out", 16'h0003, o_tally)
        rd(`DEV_ADDR, `OFS_MISMATCH_TALLY, 16'h0003);
        rd(`DEV_ADDR, `OFS_MISMATCH_TALLY, 16'h0000);
        i_fast_mismatch = 1;
        tick(1);
        rd(`DEV_ADDR, `OFS_MISMATCH_TALLY, 16'h0000);
        `CHK("tally_out", 16'h0001, o_tally)
        i_fast_mismatch = 0;
        rd(`DEV_ADDR, `OFS_MISMATCH_TALLY, 16'h0001);
        for (c = 0; c < 16; c++) begin
            v = $random(seed); v[9:8] = 2'b11; v[2] = (c == 3);
            {i_lane_status, i_lane_enable, i_lane_signal_loss} = $random(seed);
            i_slow_pll_locked = $random(seed); i_lanes_aligned = (c != 5);
            wr(`DEV_ADDR, `OFS_LANE_CFG, v); rd(`DEV_ADDR, `OFS_LANE_CFG, v & 16'hF3F7);
            tick(4);
            e = i_lanes_aligned & ~v[2] & (v[5] | ~|(i_lane_signal_loss & i_lane_enable)) & (v[4] | i_slow_pll_locked);
            `CHK("picked", i_lane_status[v[13:12]], o_pick)
            `CHK("link_up", e, o_link_up)
        end
        i_nrst = 0;
        tick(2);
        i_nrst = 1;
        `CHK("check_reset", 1'b0, o_fck)
        rd(`DEV_ADDR, `OFS_LOOP_TP_CTRL, 16'h0D10);
        rd(`DEV_ADDR, `OFS_LANE_CFG, 16'h0330);
        finish_test;
    end
endmodule // loopback_pattern_lane_config_bench
